/* File: pdp_pkg.sv */
// Constants and register map for the eight-pin bidirectional port
package pdp_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_DATA    = 8'h00;
  localparam logic [7:0] ADDR_DIR     = 8'h04;
  localparam logic [7:0] ADDR_ALT     = 8'h08;
  localparam logic [7:0] ADDR_LATCH   = 8'h0C;

  // Reset values
  localparam logic [7:0] DIR_RESET    = 8'hFF;
  localparam logic [7:0] LATCH_RESET  = 8'h00;
  localparam logic [7:0] ALT_RESET    = 8'h00;

  // Pins that own a peripheral function
  localparam logic [7:0] ALT_MASK     = 8'hFD;

  // Field positions
  localparam int         PIN_COM      = 0;
  localparam int         PIN_GPIO     = 1;
  localparam int         PIN_CCP      = 2;
  localparam int         PIN_SEG_LO   = 3;

  // Bus answers
  localparam logic [1:0] RESP_OKAY    = 2'b00;
  localparam logic [1:0] RESP_SLVERR  = 2'b10;

endpackage

/* File: pdp_port.sv */
// Eight-pin bidirectional port with AXI4-Lite register access
//
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module pdp_port #(
  parameter bit PORT_PRESENT = 1'b1
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  pin_in,
  output var  logic [7:0]  pin_out,
  output var  logic [7:0]  pin_oe_n,
  input  wire logic        lcd_common_three_val,
  input  wire logic [4:0]  lcd_segment_val,
  input  wire logic        capture_compare_pwm_two_val,
  input  wire logic        capture_compare_pwm_two_drive,
  output var  logic        capture_compare_pwm_two_in
);

  // Whole block state
  typedef struct packed {
    logic [7:0]  lat;
    logic [7:0]  dir;
    logic [7:0]  alt;
    logic [7:0]  s1;
    logic [7:0]  s2;
    logic [7:0]  s3;
    logic [7:0]  lvl;
    logic [7:0]  pout;
    logic [7:0]  poe_n;
    logic        cap_in;
    logic        aw_have;
    logic [7:0]  aw_addr;
    logic        w_have;
    logic [7:0]  w_data;
    logic        w_lane0;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pdp_state_t;

  pdp_state_t s_q;
  pdp_state_t s_d;

  logic [7:0] fn_val;
  logic [7:0] fn_en;
  logic [7:0] drv_val;
  logic [7:0] drv_oe_n;

  // Peripheral value and claim per pin
  always_comb begin
    fn_val = 8'h00;
    fn_en  = 8'h00;
    fn_val[pdp_pkg::PIN_COM] = lcd_common_three_val;
    fn_en[pdp_pkg::PIN_COM]  = s_q.alt[pdp_pkg::PIN_COM];
    fn_val[pdp_pkg::PIN_CCP] = capture_compare_pwm_two_val;
    fn_en[pdp_pkg::PIN_CCP]  = s_q.alt[pdp_pkg::PIN_CCP]
                               & capture_compare_pwm_two_drive;
    fn_val[7:pdp_pkg::PIN_SEG_LO] = lcd_segment_val;
    fn_en[7:pdp_pkg::PIN_SEG_LO]  = s_q.alt[7:pdp_pkg::PIN_SEG_LO];
  end

  // Pin driver mux, peripheral over latch
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      always_comb begin
        if (!PORT_PRESENT) begin
          drv_val[gi]  = 1'b0;
          drv_oe_n[gi] = 1'b1;
        end else if (fn_en[gi] && gi != pdp_pkg::PIN_CCP) begin
          drv_val[gi]  = fn_val[gi];
          drv_oe_n[gi] = 1'b0;
        end else if (s_q.dir[gi]) begin
          drv_val[gi]  = s_q.lat[gi];
          drv_oe_n[gi] = 1'b1;
        end else begin
          drv_val[gi]  = fn_en[gi] ? fn_val[gi] : s_q.lat[gi];
          drv_oe_n[gi] = 1'b0;
        end
      end
    end
  endgenerate

  // Next state: sync, bus slave, registers
  always_comb begin
    s_d = s_q;
    // Three-stage sync, accept when last two agree
    s_d.s1 = pin_in;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    for (int i = 0; i < 8; i++) begin
      if (s_q.s2[i] == s_q.s3[i]) begin
        s_d.lvl[i] = s_q.s3[i];
      end
    end
    s_d.cap_in = s_q.lvl[pdp_pkg::PIN_CCP];
    s_d.pout   = drv_val;
    s_d.poe_n  = drv_oe_n;

    // Write address and data in either order
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_have  = 1'b1;
      s_d.w_data  = s_axi_wdata[7:0];
      s_d.w_lane0 = s_axi_wstrb[0];
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = pdp_pkg::RESP_OKAY;
      if (s_q.aw_addr[7:2] == pdp_pkg::ADDR_DATA[7:2]) begin
        if (s_q.w_lane0 && PORT_PRESENT) begin
          s_d.lat = s_q.w_data;
        end
      end else if (s_q.aw_addr[7:2] == pdp_pkg::ADDR_DIR[7:2]) begin
        if (s_q.w_lane0 && PORT_PRESENT) begin
          s_d.dir = s_q.w_data;
        end
      end else if (s_q.aw_addr[7:2] == pdp_pkg::ADDR_ALT[7:2]) begin
        if (s_q.w_lane0 && PORT_PRESENT) begin
          s_d.alt = s_q.w_data & pdp_pkg::ALT_MASK;
        end
      end else if (s_q.aw_addr[7:2] == pdp_pkg::ADDR_LATCH[7:2]) begin
        s_d.bresp = pdp_pkg::RESP_OKAY; // Read-only, write ignored
      end else begin
        s_d.bresp = pdp_pkg::RESP_SLVERR;
      end
    end
    s_d.awready = !s_d.aw_have && !s_d.bvalid;
    s_d.wready  = !s_d.w_have && !s_d.bvalid;

    // Read channel
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = pdp_pkg::RESP_OKAY;
      s_d.rdata  = 32'h0000_0000;
      if (s_axi_araddr[7:2] == pdp_pkg::ADDR_DATA[7:2]) begin
        s_d.rdata[7:0] = PORT_PRESENT ? s_q.lvl : 8'h00;
      end else if (s_axi_araddr[7:2] == pdp_pkg::ADDR_DIR[7:2]) begin
        s_d.rdata[7:0] = PORT_PRESENT ? s_q.dir : 8'h00;
      end else if (s_axi_araddr[7:2] == pdp_pkg::ADDR_ALT[7:2]) begin
        s_d.rdata[7:0] = PORT_PRESENT ? s_q.alt : 8'h00;
      end else if (s_axi_araddr[7:2] == pdp_pkg::ADDR_LATCH[7:2]) begin
        s_d.rdata[7:0] = PORT_PRESENT ? s_q.lat : 8'h00;
      end else begin
        s_d.rresp = pdp_pkg::RESP_SLVERR;
      end
    end
    s_d.arready = !s_d.rvalid;
  end

  // State register with synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q         <= '0;
      s_q.lat     <= pdp_pkg::LATCH_RESET;
      s_q.dir     <= pdp_pkg::DIR_RESET;
      s_q.alt     <= pdp_pkg::ALT_RESET;
      s_q.poe_n   <= 8'hFF;
      s_q.awready <= 1'b0;
      s_q.wready  <= 1'b0;
      s_q.arready <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from state
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready  = s_q.wready;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  assign pin_out       = s_q.pout;
  assign pin_oe_n      = s_q.poe_n;
  assign capture_compare_pwm_two_in = s_q.cap_in;

  // Checks on the block's own behaviour
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  dir_reset_a: assert property (disable iff (1'b0)
    !aresetn |=> s_q.dir == pdp_pkg::DIR_RESET && pin_oe_n == 8'hFF)
    else $error("direction not all inputs after reset");

  pin_tristate_a: assert property (
    s_q.dir[pdp_pkg::PIN_GPIO] |=> pin_oe_n[pdp_pkg::PIN_GPIO])
    else $error("input pin is driven");

  pin_drive_a: assert property (
    PORT_PRESENT && !s_q.dir[pdp_pkg::PIN_GPIO]
      |=> !pin_oe_n[pdp_pkg::PIN_GPIO]
          && pin_out[pdp_pkg::PIN_GPIO] == $past(s_q.lat[1]))
    else $error("output pin not driving latch");

  latch_write_a: assert property (
    s_q.aw_have && s_q.w_have && !s_q.bvalid && s_q.w_lane0
      && PORT_PRESENT && s_q.aw_addr[7:2] == pdp_pkg::ADDR_DATA[7:2]
      |=> s_q.lat == $past(s_q.w_data) && s_axi_bvalid)
    else $error("data write did not load latch");

  pin_level_a: assert property (
    s_q.s2 == s_q.s3 |=> s_q.lvl == $past(s_q.s3))
    else $error("stable pin level not captured");

  com_override_a: assert property (
    PORT_PRESENT && s_q.alt[pdp_pkg::PIN_COM]
      |=> !pin_oe_n[0] && pin_out[0] == $past(lcd_common_three_val))
    else $error("common output not on pin zero");

  pin_one_a: assert property (
    s_q.alt[pdp_pkg::PIN_GPIO] == 1'b0)
    else $error("pin one took a peripheral function");

  ccp_drive_a: assert property (
    PORT_PRESENT && s_q.alt[2] && capture_compare_pwm_two_drive
      && !s_q.dir[2] |=> pin_out[2] == $past(capture_compare_pwm_two_val))
    else $error("compare output not on pin two");

  seg_override_a: assert property (
    PORT_PRESENT && s_q.alt[7] ##1 s_q.alt[7]
      |-> !pin_oe_n[7] && pin_out[7] == $past(lcd_segment_val[4]))
    else $error("segment output not on pin seven");

  absent_port_a: assert property (
    !PORT_PRESENT |=> pin_oe_n == 8'hFF && s_q.lat == 8'h00)
    else $error("absent port is active");

  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");

  // Bus channel pacing: one write and one read under way at most
  write_block_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel open while answer pending");

  read_block_a: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read address open while data pending");

  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped early");

  write_answer_a: assert property (
    s_q.aw_have && s_q.w_have && !s_q.bvalid |=> s_axi_bvalid)
    else $error("write answer not raised");

  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer not raised");

  // Only the low byte carries register contents
  read_upper_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");

  // Addresses beyond the map answer with an error
  unmapped_read_a: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:4] != 4'h0
      |=> s_axi_rresp == pdp_pkg::RESP_SLVERR)
    else $error("unmapped read not refused");

  dir_write_a: assert property (
    s_q.aw_have && s_q.w_have && !s_q.bvalid && s_q.w_lane0
      && PORT_PRESENT && s_q.aw_addr[7:2] == pdp_pkg::ADDR_DIR[7:2]
      |=> s_q.dir == $past(s_q.w_data))
    else $error("direction write did not land");

  // Compare unit never drives a pin set as input
  ccp_release_a: assert property (
    s_q.dir[pdp_pkg::PIN_CCP] |=> pin_oe_n[pdp_pkg::PIN_CCP])
    else $error("pin two driven while input");

  cap_follow_a: assert property (
    PORT_PRESENT |=> capture_compare_pwm_two_in == $past(s_q.lvl[2]))
    else $error("capture input not filtered pin two");

  // Lowest segment pin, driven whatever its direction
  seg_low_a: assert property (
    PORT_PRESENT && s_q.alt[pdp_pkg::PIN_SEG_LO]
      |=> !pin_oe_n[3] && pin_out[3] == $past(lcd_segment_val[0]))
    else $error("segment output not on pin three");

endmodule // pdp_port

`default_nettype wire

/* File: pdp_pins.sv */
// Outside circuitry that settles the level on each port pin
`timescale 1ns/1ps
`default_nettype none
module pdp_pins (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  input  wire logic [7:0] ext_level,
  output var  logic [7:0] pin_level
);
  // Released pins follow the outside source, which changes every test
  assign pin_level = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule // pdp_pins
`default_nettype wire

/* File: bidirectional_port_d_tb.sv */
// Self-checking bench for the eight-pin port
`timescale 1ns/1ps
`default_nettype none
module bidirectional_port_d_tb;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        lcd_common_three_val, capture_compare_pwm_two_val;
  logic        capture_compare_pwm_two_drive, capture_compare_pwm_two_in;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, pin_in, pin_out, pin_oe_n, ext;
  logic [31:0] s_axi_wdata, s_axi_rdata, r, q;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [4:0]  lcd_segment_val;
  logic [7:0]  dir, lat, alt, rd, lv, eo, ep;
  int          bad_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
  logic [31:0] seed = 32'h0001_6141;

  pdp_port u_pdp_port (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out,
    .pin_oe_n, .lcd_common_three_val, .lcd_segment_val,
    .capture_compare_pwm_two_val, .capture_compare_pwm_two_drive,
    .capture_compare_pwm_two_in);
  pdp_pins u_pdp_pins (.pin_out, .pin_oe_n, .ext_level(ext),
    .pin_level(pin_in));

  // Clock and hang guard
  initial begin
    aclk = 1'h0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      give_verdict();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected enables, driven values and read levels
  function automatic void expect_pins();
    logic [7:0] m;
    m = alt & 8'hF9;
    eo = dir & ~m;
    ep = (lat & ~m) | ({lcd_segment_val, 2'h0, lcd_common_three_val} & m);
    if (alt[2] && capture_compare_pwm_two_drive) begin
      ep[2] = capture_compare_pwm_two_val;
    end
    lv = (ep & ~eo) | (ext & eo);
  endfunction

  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask

  task automatic chk2(input string n, input logic [1:0] e, input logic [1:0] s);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask

  // Bus write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bit ad;
    bit dd;
    ad = 0;
    dd = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (s_axi_awready && !ad) begin
        ad = 1;
        s_axi_awvalid <= 1'h0;
      end
      if (s_axi_wready && !dd) begin
        dd = 1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
    rsp = s_axi_bresp;
  endtask

  // Bus read
  task automatic rdr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    rd = s_axi_rdata[7:0];
    rsp = s_axi_rresp;
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3_1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ext} = 56'h0;
    {lcd_common_three_val, lcd_segment_val} = 6'h00;
    {capture_compare_pwm_two_val, capture_compare_pwm_two_drive} = 2'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rdr(pdp_pkg::ADDR_DIR); chk8("dir reset", 8'hFF, rd);
    wr(pdp_pkg::ADDR_DATA, 8'h00);
    wr(pdp_pkg::ADDR_DIR, 8'hFF);
    for (int i = 0; i < 40; i++) begin
      r = rnd();
      q = rnd();
      lat = r[7:0];
      dir = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : r[15:8];
      alt = (i < 15) ? 8'h00 : (i == 39) ? 8'hFF : r[23:16];
      ext <= r[31:24];
      {lcd_common_three_val, lcd_segment_val} <= q[5:0];
      capture_compare_pwm_two_val <= q[6];
      capture_compare_pwm_two_drive <= q[7];
      wr(pdp_pkg::ADDR_DATA, lat);
      wr(pdp_pkg::ADDR_DIR, dir);
      wr(pdp_pkg::ADDR_ALT, alt); chk2("wresp", pdp_pkg::RESP_OKAY, rsp);
      rdr(pdp_pkg::ADDR_ALT); chk8("alt", alt & 8'hFD, rd);
      repeat (6) @(posedge aclk);
      expect_pins();
      chk8("oe_n", eo, pin_oe_n);
      chk8("out", ep & ~eo, pin_out & ~eo);
      rdr(pdp_pkg::ADDR_DATA); chk8("level", lv, rd);
      chk8("capture", {7'h00, lv[2]}, {7'h00, capture_compare_pwm_two_in});
    end
    wr(pdp_pkg::ADDR_LATCH, ~lat);
    rdr(pdp_pkg::ADDR_LATCH); chk8("latch", lat, rd);
    rdr(8'h10); chk2("unmapped", pdp_pkg::RESP_SLVERR, rsp);
    give_verdict();
  end
endmodule // bidirectional_port_d_tb
`default_nettype wire
